// ---- logic/pdc_pkg.sv ----
// shared constants and types for the pulse dimming link
package pdc_pkg;
    // =========================================================
    // clock and timing
    localparam int CLK_HZ          = 20_000_000;
    localparam int SETUP_US        = 10;
    localparam int PULSE_MIN_NS    = 300;
    localparam int PULSE_MAX_US    = 200;
    localparam int SPACE_MIN_NS    = 300;
    localparam int OFF_US          = 1500;
    localparam int PUMP_DELAY_US   = 400;
    localparam int SETUP_CYC       = (SETUP_US * (CLK_HZ / 1_000_000));
    localparam int PULSE_MIN_CYC   = (PULSE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int PULSE_MAX_CYC   = PULSE_MAX_US * (CLK_HZ / 1_000_000);
    localparam int SPACE_MIN_CYC   = (SPACE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int OFF_CYC         = OFF_US * (CLK_HZ / 1_000_000);
    localparam int PUMP_DELAY_CYC  = PUMP_DELAY_US * (CLK_HZ / 1_000_000);
    // =========================================================
    // current levels, tenths of a milliamp
    localparam int LEVELS          = 32;
    localparam int CUR_W           = 11;
    localparam logic [4:0] LVL_FULL = 5'h00;
    localparam logic [4:0] LVL_ZERO = 5'h1F;
    typedef logic [CUR_W-1:0] pdc_cur_t;
    localparam pdc_cur_t CUR_TABLE [LEVELS] = '{
        11'h5DC, 11'h5AA, 11'h578, 11'h54B, 11'h51E, 11'h4EC, 11'h4BA, 11'h488,
        11'h456, 11'h429, 11'h3F7, 11'h3CA, 11'h398, 11'h366, 11'h334, 11'h307,
        11'h2D5, 11'h2A8, 11'h276, 11'h244, 11'h212, 11'h1E5, 11'h1B3, 11'h186,
        11'h154, 11'h122, 11'h0F0, 11'h0BE, 11'h091, 11'h064, 11'h032, 11'h000
    };
    typedef enum logic [1:0] {
        PDC_SHUT, PDC_ARMED, PDC_ACTIVE
    } pdc_state_e;
    typedef enum logic {
        PDC_PUMP_1X, PDC_PUMP_1P5X
    } pdc_pump_e;
endpackage

// ---- logic/pdc_link_if.sv ----
// single wire enable/dimming link between host and driver
interface pdc_link_if;
    logic enable_dim_line;
    modport host_end (output enable_dim_line);
    modport dev_end  (input  enable_dim_line);
endinterface

// ---- logic/pdc_driver.sv ----
// driver end: pulse counting, shutdown timing and pump mode sequencing

// Overview of operation
// - first high enables, currents stay zero
// - first falling edge sets full scale
// - each further falling edge steps down
// - thirty-second pulse gives zero, still enabled
// - pulse after zero wraps to full
// - long low time enters shutdown
// - shutdown sinks high impedance, no current
// - undervoltage disables all channels
// - pump starts in unity gain
// - unity gain while regulation holds
// - switch to 1.5x after delay
// - sequence restarts on power-up, shutdown exit
// - host holds line high for setup
// - host pulse width within limits
// - host keeps minimum high between pulses
// - pulse rates up to 1 MHz counted
// - pulse count maps to current table
module pdc_driver #(
    parameter int OFF_CYCLES  = pdc_pkg::OFF_CYC,        // low time to shutdown
    parameter int PUMP_CYCLES = pdc_pkg::PUMP_DELAY_CYC  // 1x dwell before 1.5x
) (
    input  wire logic          clk,            // 20 MHz clock
    input  wire logic          rst,            // async reset, active high
    pdc_link_if.dev_end        link,           // enable/dimming line
    input  wire logic          supply_low,     // supply below undervoltage threshold
    input  wire logic          reg_fail,       // currents cannot be regulated
    output pdc_pkg::pdc_cur_t  led_sink_a,     // channel a current, 0.1 mA units
    output pdc_pkg::pdc_cur_t  led_sink_b,     // channel b current, 0.1 mA units
    output logic               sink_hiz,       // channels high impedance
    output logic               enabled,        // device out of shutdown
    output pdc_pkg::pdc_pump_e pump_mode       // charge pump gain
);
    import pdc_pkg::*;

    localparam int TW = $clog2(OFF_CYCLES + PUMP_CYCLES + 2);

    typedef struct packed {
        logic [2:0]  sync;
        logic        line;
        pdc_state_e  state;
        logic [4:0]  level;
        logic [TW-1:0] low_cnt;
        logic [TW-1:0] pump_cnt;
        pdc_pump_e   pump;
        pdc_cur_t    cur;
        logic        hiz;
    } pdc_drv_s;

    pdc_drv_s r;
    pdc_drv_s next_r;
    logic     fall;
    logic     rise;

    // =========================================================
    // next state
    always_comb begin
        next_r = r;
        next_r.sync = {r.sync[1:0], link.enable_dim_line};
        // metastable stage is sync[0]; only agreeing later stages count
        if (r.sync[1] == r.sync[2]) begin
            next_r.line = r.sync[2];
        end
        fall = r.line && !next_r.line;
        rise = !r.line && next_r.line;
        case (r.state)
            PDC_SHUT: begin
                if (next_r.line) begin
                    next_r.state    = PDC_ARMED;
                    next_r.pump     = PDC_PUMP_1X;
                    next_r.pump_cnt = '0;
                end
            end
            PDC_ARMED: begin
                // first falling edge is full scale
                if (fall) begin
                    next_r.state = PDC_ACTIVE;
                    next_r.level = LVL_FULL;
                end
            end
            PDC_ACTIVE: begin
                // step down and wrap; edge per pulse
                if (fall) begin
                    next_r.level = (r.level == LVL_ZERO) ? LVL_FULL : r.level + 5'h01;
                end
            end
            default: next_r.state = PDC_SHUT;
        endcase
        // low timer restarts on every rise
        if (rise || next_r.line || r.state == PDC_SHUT) begin
            next_r.low_cnt = '0;
        end else if (r.low_cnt < TW'(OFF_CYCLES)) begin
            next_r.low_cnt = r.low_cnt + 1'b1;
        end
        if (r.state != PDC_SHUT && r.low_cnt >= TW'(OFF_CYCLES - 1) && !next_r.line) begin
            next_r.state = PDC_SHUT;
            next_r.level = LVL_FULL;
        end
        if (r.state == PDC_SHUT) begin
            next_r.pump     = PDC_PUMP_1X;
            next_r.pump_cnt = '0;
        end else if (r.pump == PDC_PUMP_1X && reg_fail) begin
            if (r.pump_cnt >= TW'(PUMP_CYCLES - 1)) begin
                next_r.pump = PDC_PUMP_1P5X;
            end else begin
                next_r.pump_cnt = r.pump_cnt + 1'b1;
            end
        end else if (r.pump == PDC_PUMP_1X) begin
            next_r.pump_cnt = '0;
        end
        next_r.hiz = (next_r.state == PDC_SHUT);
        if (next_r.state != PDC_ACTIVE || supply_low) begin
            next_r.cur = '0;
        end else begin
            next_r.cur = CUR_TABLE[next_r.level];
        end
    end

    // =========================================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '{sync: 3'h0, line: 1'b0, state: PDC_SHUT, level: LVL_FULL,
                   low_cnt: '0, pump_cnt: '0, pump: PDC_PUMP_1X, cur: '0, hiz: 1'b1};
        end else begin
            r <= next_r;
        end
    end

    assign led_sink_a = r.cur;
    assign led_sink_b = r.cur;
    assign sink_hiz   = r.hiz;
    assign enabled    = (r.state != PDC_SHUT);
    assign pump_mode  = r.pump;
endmodule

// ---- logic/pdc_host.sv ----
// host end: turns wake, step and shutdown commands into timed pulses on the line

module pdc_host #(
    parameter int OFF_CYCLES = pdc_pkg::OFF_CYC  // low time that forces shutdown
) (
    input  wire logic          clk,          // 20 MHz clock
    input  wire logic          rst,          // async reset, active high
    pdc_link_if.host_end       link,         // enable/dimming line
    input  wire logic          cmd_on,       // pulse: wake from shutdown
    input  wire logic          cmd_step,     // pulse: one dimming pulse
    input  wire logic          cmd_off,      // pulse: go to shutdown
    output logic               busy          // command in progress
);
    import pdc_pkg::*;

    localparam int TW = $clog2(OFF_CYCLES + SETUP_CYC + 2);

    typedef enum logic [2:0] {
        HS_OFF, HS_SETUP, HS_IDLE, HS_LOW, HS_HIGH, HS_SHUT
    } pdc_hstate_e;

    typedef struct packed {
        pdc_hstate_e   state;
        logic          line;
        logic [TW-1:0] cnt;
    } pdc_host_s;

    pdc_host_s r;
    pdc_host_s next_r;

    always_comb begin
        next_r = r;
        next_r.cnt = (r.cnt == '0) ? '0 : r.cnt - 1'b1;
        case (r.state)
            HS_OFF: begin
                if (cmd_on) begin
                    next_r.state = HS_SETUP;
                    next_r.line  = 1'b1;
                    next_r.cnt   = TW'(SETUP_CYC - 1);
                end
            end
            HS_SETUP: begin
                if (r.cnt == '0) begin
                    next_r.state = HS_IDLE;
                end
            end
            HS_IDLE: begin
                if (cmd_off) begin
                    next_r.state = HS_SHUT;
                    next_r.line  = 1'b0;
                    next_r.cnt   = TW'(OFF_CYCLES - 1);
                end else if (cmd_step) begin
                    next_r.state = HS_LOW;
                    next_r.line  = 1'b0;
                    // low pulse at least minimum width
                    next_r.cnt   = TW'(PULSE_MIN_CYC - 1);
                end
            end
            HS_LOW: begin
                if (r.cnt == '0) begin
                    next_r.state = HS_HIGH;
                    next_r.line  = 1'b1;
                    next_r.cnt   = TW'(SPACE_MIN_CYC - 1);
                end
            end
            HS_HIGH: begin
                if (r.cnt == '0) begin
                    next_r.state = HS_IDLE;
                end
            end
            HS_SHUT: begin
                if (r.cnt == '0) begin
                    next_r.state = HS_OFF;
                end
            end
            default: next_r.state = HS_OFF;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '{state: HS_OFF, line: 1'b0, cnt: '0};
        end else begin
            r <= next_r;
        end
    end

    assign link.enable_dim_line = r.line;
    assign busy = (r.state != HS_IDLE) && (r.state != HS_OFF);
endmodule

// ---- verif/pdc_link_props.sv ----
// concurrent checks on the enable/dimming link and driver outputs
module pdc_link_props
    import pdc_pkg::*;
(
    input wire logic      clk,             // 20 MHz clock
    input wire logic      rst,             // async reset, active high
    input wire logic      enable_dim_line, // link level
    input wire logic      supply_low,      // undervoltage flag
    input wire logic      reg_fail,        // regulation lost
    input wire pdc_cur_t  led_sink_a,      // channel a current
    input wire pdc_cur_t  led_sink_b,      // channel b current
    input wire logic      sink_hiz,        // channels high impedance
    input wire logic      enabled,         // out of shutdown
    input wire pdc_pump_e pump_mode        // pump gain
);
    // ==================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_HIZ_ZERO: assert property (sink_hiz |-> led_sink_a == '0 && led_sink_b == '0)
        else $error("current flows while sinks are high impedance");
    AST_UVLO_OFF: assert property (supply_low |=> led_sink_a == '0 && led_sink_b == '0)
        else $error("current flows in undervoltage");
    AST_MATCH: assert property (led_sink_a == led_sink_b)
        else $error("channel currents differ");
    AST_WAKE_ZERO: assert property ($rose(enabled) |-> (led_sink_a == '0) [*8])
        else $error("current not zero after wake");
    AST_WAKE_1X: assert property ($rose(enabled) |-> pump_mode == PDC_PUMP_1X)
        else $error("pump not unity gain after wake");
    AST_PUMP_UP: assert property ($rose(pump_mode == PDC_PUMP_1P5X)
        |-> $past(reg_fail, 2) && $past(reg_fail, 10))
        else $error("pump stepped up without sustained regulation loss");
    AST_SHUT_LOW: assert property ($fell(enabled)
        |-> $past(!enable_dim_line, 8) && $past(!enable_dim_line, 40))
        else $error("shutdown without long low time");
    AST_HIGH_HOLD: assert property ((enable_dim_line && !supply_low) [*8]
        |=> $stable(led_sink_a))
        else $error("current moved while line held high");
endmodule

// ---- verif/tb.sv ----
// self-checking bench joining host end and driver end over the link
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pdc_pkg::*;
    logic       clk, rst, cmd_on, cmd_step, cmd_off, supply_low, reg_fail, busy;
    logic       sink_hiz, enabled;
    pdc_cur_t   led_sink_a, led_sink_b;
    pdc_pump_e  pump_mode;
    int         fails = 0, total_checks = 0, cyc = 0;
    // expected per-channel current, tenths of a milliamp
    int lvl [32] = '{1500, 1450, 1400, 1355, 1310, 1260, 1210, 1160, 1110, 1065, 1015,
        970, 920, 870, 820, 775, 725, 680, 630, 580, 530, 485, 435, 390, 340, 290,
        240, 190, 145, 100, 50, 0};
    pdc_link_if link ();
    pdc_host #(.OFF_CYCLES(50)) u_pdc_host (.clk(clk), .rst(rst), .link(link),
        .cmd_on(cmd_on), .cmd_step(cmd_step), .cmd_off(cmd_off), .busy(busy));
    pdc_driver #(.OFF_CYCLES(50), .PUMP_CYCLES(20)) u_pdc_driver (.clk(clk), .rst(rst),
        .link(link), .supply_low(supply_low), .reg_fail(reg_fail), .led_sink_a(led_sink_a),
        .led_sink_b(led_sink_b), .sink_hiz(sink_hiz), .enabled(enabled),
        .pump_mode(pump_mode));
    pdc_link_props u_pdc_link_props (.clk(clk), .rst(rst),
        .enable_dim_line(link.enable_dim_line), .supply_low(supply_low),
        .reg_fail(reg_fail), .led_sink_a(led_sink_a), .led_sink_b(led_sink_b),
        .sink_hiz(sink_hiz), .enabled(enabled), .pump_mode(pump_mode));
    // ==================================================
    // tasks
    task chk_cur(input int e);
        total_checks += 1;
        if (led_sink_a !== pdc_cur_t'(e) || led_sink_b !== pdc_cur_t'(e)) begin
            fails += 1;
            $display("ERROR %0t current %0d expected %0d", $time, led_sink_a, e);
        end
    endtask
    task chk_bit(input logic g, input logic e);
        total_checks += 1;
        if (g !== e) begin
            fails += 1;
            $display("ERROR %0t flag %b expected %b", $time, g, e);
        end
    endtask
    task wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // kind 0 wake, 1 dimming pulse, 2 shutdown; margin covers the line synchroniser
    task send(input int k);
        int n;
        n = 0;
        @(posedge clk);
        cmd_on   <= (k == 0);
        cmd_step <= (k == 1);
        cmd_off  <= (k == 2);
        @(posedge clk);
        {cmd_on, cmd_step, cmd_off} <= 3'h0;
        do begin
            @(negedge clk);
            n += 1;
        end while (busy !== 1'b0 && n < 2000);
        if (n >= 2000) begin
            fails += 1;
            $display("ERROR %0t host stays busy", $time);
        end
        wait_cyc(8);
    endtask
    task results;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ==================================================
    // clock, timeout, sequence
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc += 1;
        if (cyc == 20000) begin
            fails += 1;
            $display("ERROR %0t timeout", $time);
            results;
        end
    end
    initial begin
        rst = 1'b1;
        {cmd_on, cmd_step, cmd_off, supply_low, reg_fail} = 5'h00;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        wait_cyc(2);
        chk_bit(sink_hiz, 1'b1);
        chk_bit(pump_mode, 1'b0);
        send(0);
        chk_bit(enabled, 1'b1);
        chk_cur(0);
        $display("wake test done");
        // full stepping cycle; short lows must never add up to shutdown
        for (int i = 0; i < 33; i++) begin
            send(1);
            chk_cur(lvl[i % 32]);
        end
        chk_bit(enabled, 1'b1);
        $display("dimming test done");
        @(posedge clk) supply_low <= 1'b1;
        wait_cyc(3);
        chk_cur(0);
        @(posedge clk) supply_low <= 1'b0;
        wait_cyc(3);
        chk_cur(lvl[0]);
        $display("undervoltage test done");
        @(posedge clk) reg_fail <= 1'b1;
        wait_cyc(10);
        @(posedge clk) reg_fail <= 1'b0;
        wait_cyc(20);
        chk_bit(pump_mode, 1'b0);
        @(posedge clk) reg_fail <= 1'b1;
        wait_cyc(30);
        chk_bit(pump_mode, 1'b1);
        $display("pump test done");
        send(2);
        chk_bit(enabled, 1'b0);
        chk_bit(sink_hiz, 1'b1);
        chk_cur(0);
        @(posedge clk) reg_fail <= 1'b0;
        send(0);
        chk_bit(pump_mode, 1'b0);
        send(1);
        chk_cur(lvl[0]);
        $display("shutdown test done");
        results;
    end
endmodule
